// ---- core/dprc_dual_port.sv ----
// two-port synchronous pipelined ram with port control and mailboxes
//
// What this block does
// - output enable acts asynchronously; other port inputs sampled on rising clock edge.
// - deasserted chip select puts data lines high impedance after the second edge.
// - strobe and advance low with counter select high loads address each edge.
// - output state each cycle follows the controls registered a cycle earlier.
// - first write after a read with output enable low is a no-operation.
// - counter reset adds no dead cycle; access happens in the same cycle.
// - after wrapping to the loaded value, increment repeats the same block.
// - readback drives counter or mask on address lines, chosen by select.
// - write then read of one location gives new data one cycle later.
// - wrap flag always driven, low when unmasked counter reaches its maximum.
// - right port mailbox at top address; a write to it from the left port raises right interrupt.
// - mailbox flag set on writer's edge, cleared on reader's edge.
// - chip select changes take effect after one cycle of latency.
`timescale 1ns/1ps
`default_nettype none
module dprc_dual_port
    import dprc_pkg::*;
(
    // clock and master reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // port controls, index 0 left, 1 right
    input wire dprc_ctl_s [NPORT-1:0] port_ctl,
    input wire logic [NPORT-1:0] output_enable_n,
    // address lines, two-way
    input wire logic [NPORT-1:0][ADDR_W-1:0] addr_in,
    output logic [NPORT-1:0][ADDR_W-1:0] addr_out,
    output logic [NPORT-1:0] addr_oe_n,
    // data lines, two-way
    input wire logic [NPORT-1:0][DATA_W-1:0] data_lines_in,
    output logic [NPORT-1:0][DATA_W-1:0] data_lines_out,
    output logic [NPORT-1:0] data_lines_oe_n,
    // flags
    output logic [NPORT-1:0] counter_wrap_flag_n,
    output logic [NPORT-1:0] mailbox_flag_n
);

    // storage shared by both ports
    logic [DATA_W-1:0] mem [DEPTH];

    // per-port pipeline state seen by the shared logic
    dprc_bus_e bus_q [NPORT];
    dprc_req_s req_q [NPORT];
    logic [DATA_W-1:0] rd_word [NPORT];
    logic [ADDR_W-1:0] mbox_addr [NPORT];

    // mailbox flags
    logic [NPORT-1:0] mbox_r, mbox_nxt;
    logic [NPORT-1:0] mbox_set, mbox_clr;

    assign mbox_addr[0] = MBOX_ADDR_LEFT;
    assign mbox_addr[1] = MBOX_ADDR_RIGHT;

    genvar p;
    generate
        for (p = 0; p < NPORT; p++) begin : g_port
            dprc_bus_e state_r, state_nxt;
            dprc_req_s req_r, req_nxt;
            logic drive_r, drive_nxt;
            logic [DATA_W-1:0] dout_r, dout_nxt;
            logic oe_meta_r, oe_sync_r;
            logic selected;
            logic [ADDR_W-1:0] acc_addr;
            logic rb_drive;
            logic [ADDR_W-1:0] rb_value;

            dprc_addr_counter u_counter (
                .clk_sys(clk_sys),
                .rst_n(rst_n),
                .ctl(port_ctl[p]),
                .addr_in(addr_in[p]),
                .access_addr(acc_addr),
                .wrap_flag_n(counter_wrap_flag_n[p]),
                .readback_drive(rb_drive),
                .readback_value(rb_value)
            );

            assign addr_oe_n[p] = !rb_drive;
            assign addr_out[p] = rb_value;

            always_comb begin
                selected = !port_ctl[p].chip_select_low_active
                    && port_ctl[p].chip_select_high_active;
                state_nxt = BUS_IDLE;
                if (selected) begin
                    if (port_ctl[p].read_write) begin
                        state_nxt = BUS_READ;
                    end else if (state_r == BUS_READ && !oe_sync_r) begin
                        state_nxt = BUS_NOP;
                    end else begin
                        state_nxt = BUS_WRITE;
                    end
                end
                req_nxt.addr = acc_addr;
                req_nxt.wdata = data_lines_in[p];
                req_nxt.lanes = ~{port_ctl[p].byte_lane_enable_high_n,
                    port_ctl[p].byte_lane_enable_low_n};
                drive_nxt = 1'b0;
                dout_nxt = dout_r;
                unique case (state_r)
                    BUS_IDLE: begin
                        drive_nxt = 1'b0;
                    end
                    BUS_READ: begin
                        drive_nxt = 1'b1;
                        dout_nxt = rd_word[p];
                    end
                    BUS_WRITE: begin
                        drive_nxt = 1'b0;
                    end
                    BUS_NOP: begin
                        drive_nxt = 1'b0;
                    end
                endcase
            end

            always_ff @(posedge clk_sys or negedge rst_n) begin
                if (!rst_n) begin
                    state_r <= BUS_IDLE;
                    req_r <= '0;
                    drive_r <= 1'b0;
                    dout_r <= DOUT_RST_VAL;
                    oe_meta_r <= 1'b1;
                    oe_sync_r <= 1'b1;
                end else begin
                    state_r <= state_nxt;
                    req_r <= req_nxt;
                    drive_r <= drive_nxt;
                    dout_r <= dout_nxt;
                    oe_meta_r <= output_enable_n[p];
                    oe_sync_r <= oe_meta_r;
                end
            end

            assign data_lines_oe_n[p] = !(drive_r && !output_enable_n[p]);
            assign data_lines_out[p] = dout_r;

            assign bus_q[p] = state_r;
            assign req_q[p] = req_r;
            // read sees writes of earlier edges only
            assign rd_word[p] = mem[req_r.addr];
        end
    endgenerate

    // writes of both ports, lane by lane
    always_ff @(posedge clk_sys) begin
        for (int i = 0; i < NPORT; i++) begin
            for (int l = 0; l < NLANE; l++) begin
                if (bus_q[i] == BUS_WRITE && req_q[i].lanes[l]) begin
                    mem[req_q[i].addr][l*LANE_W +: LANE_W] <=
                        req_q[i].wdata[l*LANE_W +: LANE_W];
                end
            end
        end
    end

    always_comb begin
        for (int q = 0; q < NPORT; q++) begin
            // set by the other port's write
            mbox_set[q] = bus_q[NPORT-1-q] == BUS_WRITE
                && req_q[NPORT-1-q].addr == mbox_addr[q]
                && req_q[NPORT-1-q].lanes != 2'b00;
            mbox_clr[q] = bus_q[q] == BUS_READ
                && req_q[q].addr == mbox_addr[q];
            // set wins over clear
            mbox_nxt[q] = mbox_set[q] || (mbox_r[q] && !mbox_clr[q]);
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            mbox_r <= '0;
        end else begin
            mbox_r <= mbox_nxt;
        end
    end

    assign mailbox_flag_n = ~mbox_r;

endmodule
`default_nettype wire

// ---- core/dprc_pkg.sv ----
// shared constants and types of the dual-port ram port control
package dprc_pkg;

    // array shape
    localparam int NPORT = 2;
    localparam int DATA_W = 18;
    localparam int LANE_W = 9;
    localparam int NLANE = 2;
    localparam int ADDR_W = 19;
    localparam int DEPTH = 524288;

    // mailbox locations, one per port
    localparam logic [ADDR_W-1:0] MBOX_ADDR_LEFT = 19'h7fffe;
    localparam logic [ADDR_W-1:0] MBOX_ADDR_RIGHT = 19'h7ffff;

    // reset values
    localparam logic [ADDR_W-1:0] CNT_RST_VAL = 19'h00000;
    localparam logic [ADDR_W-1:0] MASK_RST_VAL = 19'h7ffff;
    localparam logic [DATA_W-1:0] DOUT_RST_VAL = 18'h00000;

    // pin controls of one port, sampled on the port clock
    typedef struct packed {
        logic chip_select_low_active;
        logic chip_select_high_active;
        logic read_write;
        logic address_strobe_n;
        logic counter_advance_n;
        logic counter_clear_n;
        logic counter_or_mask_select;
        logic byte_lane_enable_low_n;
        logic byte_lane_enable_high_n;
    } dprc_ctl_s;

    // one captured access
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic [NLANE-1:0] lanes;
    } dprc_req_s;

    // what the captured cycle does on the data lines
    typedef enum {
        BUS_IDLE,
        BUS_READ,
        BUS_WRITE,
        BUS_NOP
    } dprc_bus_e;

    // address counter operation
    typedef enum {
        CNT_HOLD,
        CNT_CLEAR,
        CNT_LOAD,
        CNT_INC,
        CNT_READBACK
    } dprc_cnt_op_e;

endpackage

// ---- core/dprc_addr_counter.sv ----
// burst address counter with mask, retransmit, wrap flag and readback
`timescale 1ns/1ps
`default_nettype none
module dprc_addr_counter
    import dprc_pkg::*;
(
    // clock and master reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // port controls and address pins
    input wire dprc_ctl_s ctl,
    input wire logic [ADDR_W-1:0] addr_in,
    // address used by this cycle's access
    output logic [ADDR_W-1:0] access_addr,
    // status and readback
    output logic wrap_flag_n,
    output logic readback_drive,
    output logic [ADDR_W-1:0] readback_value
);

    dprc_cnt_op_e op;
    logic [ADDR_W-1:0] cnt_r, cnt_nxt;
    logic [ADDR_W-1:0] mask_r, mask_nxt;
    logic [ADDR_W-1:0] base_r, base_nxt;
    logic wrap_r, wrap_nxt;
    logic rb_r, rb_nxt;
    logic [ADDR_W-1:0] rbv_r, rbv_nxt;
    logic [ADDR_W-1:0] step;

    always_comb begin
        op = CNT_HOLD;
        if (!ctl.counter_clear_n) begin
            op = CNT_CLEAR;
        end else if (!ctl.address_strobe_n && !ctl.counter_advance_n) begin
            op = CNT_LOAD;
        end else if (!ctl.counter_advance_n && ctl.counter_or_mask_select) begin
            op = CNT_INC;
        end else if (!ctl.address_strobe_n) begin
            op = CNT_READBACK;
        end
        step = ((cnt_r & mask_r) + 19'h00001) & mask_r;
        cnt_nxt = cnt_r;
        mask_nxt = mask_r;
        base_nxt = base_r;
        wrap_nxt = wrap_r;
        rb_nxt = 1'b0;
        rbv_nxt = rbv_r;
        unique case (op)
            CNT_HOLD: begin
            end
            CNT_CLEAR: begin
                if (ctl.counter_or_mask_select) begin
                    cnt_nxt = CNT_RST_VAL;
                    base_nxt = CNT_RST_VAL;
                    wrap_nxt = 1'b1;
                end else begin
                    mask_nxt = MASK_RST_VAL;
                end
            end
            CNT_LOAD: begin
                if (ctl.counter_or_mask_select) begin
                    cnt_nxt = addr_in;
                    base_nxt = addr_in;
                    wrap_nxt = 1'b1;
                end else begin
                    mask_nxt = addr_in;
                end
            end
            CNT_INC: begin
                if ((cnt_r & mask_r) == mask_r) begin
                    cnt_nxt = base_r;
                end else begin
                    cnt_nxt = (cnt_r & ~mask_r) | step;
                end
                wrap_nxt = !((cnt_nxt & mask_r) == mask_r);
            end
            CNT_READBACK: begin
                rb_nxt = 1'b1;
                rbv_nxt = ctl.counter_or_mask_select ? cnt_r : mask_r;
            end
        endcase
    end

    assign access_addr = cnt_nxt;
    assign wrap_flag_n = wrap_r;
    assign readback_drive = rb_r;
    assign readback_value = rbv_r;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            cnt_r <= CNT_RST_VAL;
            mask_r <= MASK_RST_VAL;
            base_r <= CNT_RST_VAL;
            wrap_r <= 1'b1;
            rb_r <= 1'b0;
            rbv_r <= CNT_RST_VAL;
        end else begin
            cnt_r <= cnt_nxt;
            mask_r <= mask_nxt;
            base_r <= base_nxt;
            wrap_r <= wrap_nxt;
            rb_r <= rb_nxt;
            rbv_r <= rbv_nxt;
        end
    end

endmodule
`default_nettype wire

// ---- sim/dprc_dual_port_sva.sv ----
// pin-level assertions for the dual-port ram port control
`timescale 1ns/1ps
`default_nettype none
module dprc_dual_port_sva
    import dprc_pkg::*;
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // port pins
    input wire dprc_ctl_s [NPORT-1:0] port_ctl,
    input wire logic [NPORT-1:0] output_enable_n,
    input wire logic [NPORT-1:0][ADDR_W-1:0] addr_in,
    input wire logic [NPORT-1:0][ADDR_W-1:0] addr_out,
    input wire logic [NPORT-1:0] addr_oe_n,
    input wire logic [NPORT-1:0] data_lines_oe_n,
    input wire logic [NPORT-1:0] counter_wrap_flag_n,
    input wire logic [NPORT-1:0] mailbox_flag_n
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    wire [NPORT-1:0] sel;
    wire [NPORT-1:0][3:0] op;
    for (genvar p = 0; p < NPORT; p++) begin : g_dec
        assign sel[p] = !port_ctl[p].chip_select_low_active & port_ctl[p].chip_select_high_active;
        assign op[p] = {port_ctl[p].address_strobe_n, port_ctl[p].counter_advance_n,
                        port_ctl[p].counter_clear_n, port_ctl[p].counter_or_mask_select};
    end
    sequence s_ld_cnt; op[0] == 4'h3; endsequence
    sequence s_rb_cnt; op[0] == 4'h7; endsequence
    sequence s_clr_msk; op[0] == 4'hc; endsequence
    sequence s_rb_msk; op[0] == 4'h6; endsequence
    sequence s_mbox_wr;
        sel[0] && !port_ctl[0].read_write && op[0] == 4'h3 && addr_in[0] == MBOX_ADDR_RIGHT
        && !(port_ctl[0].byte_lane_enable_low_n && port_ctl[0].byte_lane_enable_high_n);
    endsequence
    AST_DESEL_HIZ: assert property (!sel[0] |-> ##2 data_lines_oe_n[0])
        else $error("data lines driven after deselect");
    AST_OE_ASYNC: assert property (output_enable_n[0] |-> data_lines_oe_n[0])
        else $error("data lines driven with output enable off");
    AST_READ_DRIVE: assert property (sel[0] && port_ctl[0].read_write ##1 1'b1 ##1
        !output_enable_n[0] |-> !data_lines_oe_n[0])
        else $error("read data not driven one cycle after the read");
    AST_WRITE_HIZ: assert property (sel[0] && !port_ctl[0].read_write |-> ##2 data_lines_oe_n[0])
        else $error("data lines driven for a write");
    AST_RB_CNT: assert property (s_ld_cnt ##1 s_rb_cnt |=>
        !addr_oe_n[0] && addr_out[0] == $past(addr_in[0], 2))
        else $error("counter readback wrong");
    AST_RB_MSK: assert property (s_clr_msk ##1 s_rb_msk |=> addr_out[0] == MASK_RST_VAL)
        else $error("mask readback wrong");
    AST_WRAP_CLR: assert property (op[0] == 4'hd |=> counter_wrap_flag_n[0])
        else $error("wrap flag low after counter clear");
    AST_MBOX_SET: assert property (!(sel[0] && port_ctl[0].read_write) ##1 s_mbox_wr
        |-> ##2 !mailbox_flag_n[1])
        else $error("mailbox flag not set by write");
    AST_MBOX_CLR: assert property (sel[1] && port_ctl[1].read_write && op[1] == 4'h3
        && !sel[0] && addr_in[1] == MBOX_ADDR_RIGHT |-> ##2 mailbox_flag_n[1])
        else $error("mailbox flag not cleared by read");
endmodule
`default_nettype wire

// ---- sim/dprc_host_model.sv ----
// host model of one port: resolves the two-way address and data pins
`timescale 1ns/1ps
`default_nettype none
module dprc_host_model
    import dprc_pkg::*;
(
    // clock
    input wire logic clk_sys,
    // host side drive
    input wire logic [ADDR_W-1:0] a_host,
    input wire logic a_en,
    input wire logic [DATA_W-1:0] d_host,
    input wire logic d_en,
    // device side drive
    input wire logic [ADDR_W-1:0] a_dev,
    input wire logic a_oe_n,
    input wire logic [DATA_W-1:0] d_dev,
    input wire logic d_oe_n,
    // resolved pins
    output logic [ADDR_W-1:0] a_pin,
    output logic [DATA_W-1:0] d_pin
);
    logic [ADDR_W-1:0] a_last = '0;
    logic [DATA_W-1:0] d_last = '0;
    // host off the address pins in readback
    always_comb a_pin = !a_oe_n ? a_dev : (a_en ? a_host : ~a_last);
    always_comb d_pin = !d_oe_n ? d_dev : (d_en ? d_host : ~d_last);
    // undriven pins toggle so a stale value never reads as valid
    always_ff @(posedge clk_sys) begin
        a_last <= a_pin;
        d_last <= d_pin;
    end
endmodule
`default_nettype wire

// ---- sim/dprc_dual_port_tb.sv ----
// self-checking bench for the dual-port ram port control
`timescale 1ns/1ps
`default_nettype none
module dprc_dual_port_tb
    import dprc_pkg::*;
;
    localparam dprc_ctl_s IDLE = 9'h17c;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    dprc_ctl_s [NPORT-1:0] ctl;
    logic [NPORT-1:0] oe_n, aoe_n, doe_n, wrap_n, mbox_n, a_en, d_en;
    logic [NPORT-1:0][ADDR_W-1:0] a_h, a_pin, a_out;
    logic [NPORT-1:0][DATA_W-1:0] d_h, d_pin, d_out;
    logic [DATA_W-1:0] mem [logic [ADDR_W-1:0]];
    int error_cnt = 0, compares = 0, cyc = 0, seed = 32'h0910;
    initial forever #12.5 clk_sys = ~clk_sys;
    dprc_dual_port i_dut (.clk_sys(clk_sys), .rst_n(rst_n), .port_ctl(ctl),
        .output_enable_n(oe_n), .addr_in(a_pin), .addr_out(a_out), .addr_oe_n(aoe_n),
        .data_lines_in(d_pin), .data_lines_out(d_out), .data_lines_oe_n(doe_n),
        .counter_wrap_flag_n(wrap_n), .mailbox_flag_n(mbox_n));
    for (genvar p = 0; p < NPORT; p++) begin : g_host
        dprc_host_model i_host (.clk_sys(clk_sys), .a_host(a_h[p]), .a_en(a_en[p]),
            .d_host(d_h[p]), .d_en(d_en[p]), .a_dev(a_out[p]), .a_oe_n(aoe_n[p]),
            .d_dev(d_out[p]), .d_oe_n(doe_n[p]), .a_pin(a_pin[p]), .d_pin(d_pin[p]));
    end
    task automatic chk_w(string n, logic [ADDR_W-1:0] e, logic [ADDR_W-1:0] s);
        compares++;
        if (s !== e) begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic chk_b(string n, logic e, logic s);
        compares++;
        if (s !== e) begin
            error_cnt++;
            $display("mismatch %s expected %b seen %b", n, e, s);
        end
    endtask
    task automatic summarize();
        $display("compares %0d errors %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // lanes are active low: ln[1] low lane, ln[0] high lane
    function automatic logic [DATA_W-1:0] merge(logic [DATA_W-1:0] o, n, logic [1:0] ln);
        merge = o;
        if (!ln[1]) merge[8:0] = n[8:0];
        if (!ln[0]) merge[17:9] = n[17:9];
    endfunction
    task automatic drv(int p, logic rw, logic [ADDR_W-1:0] a, logic [DATA_W-1:0] d,
                       logic [1:0] ln);
        ctl[p] = '{1'b0, 1'b1, rw, 1'b0, 1'b0, 1'b1, 1'b1, ln[1], ln[0]};
        a_h[p] = a;
        a_en[p] = 1'b1;
        d_h[p] = d;
        d_en[p] = !rw;
        @(posedge clk_sys) #1;
    endtask
    task automatic idle(int p);
        ctl[p] = IDLE;
        d_en[p] = 1'b0;
    endtask
    task automatic wr(int p, logic [ADDR_W-1:0] a, logic [DATA_W-1:0] d, logic [1:0] ln);
        drv(p, 1'b0, a, d, ln);
        mem[a] = merge(mem[a], d, ln);
    endtask
    task automatic rdchk(int p, logic [ADDR_W-1:0] a);
        drv(p, 1'b1, a, '0, 2'b00);
        idle(p);
        @(posedge clk_sys) #1;
        chk_w("rdata", {1'b0, mem[a]}, {1'b0, d_out[p]});
        chk_b("rd_oe", 1'b0, doe_n[p]);
        oe_n[p] = 1'b1;
        #1 chk_b("oe_off", 1'b1, doe_n[p]);
        oe_n[p] = 1'b0;
        @(posedge clk_sys) #1;
        chk_b("desel", 1'b1, doe_n[p]);
    endtask
    // counter op on the left port, deselected; f is strobe, advance, clear, select
    task automatic cop(logic [3:0] f, logic [ADDR_W-1:0] a);
        ctl[0] = '{1'b1, 1'b0, 1'b1, f[3], f[2], f[1], f[0], 1'b1, 1'b1};
        a_h[0] = a;
        a_en[0] = f[3:1] != 3'b011;
        @(posedge clk_sys) #1;
    endtask
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            error_cnt++;
            summarize();
        end
    end
    initial begin
        logic [ADDR_W-1:0] a;
        logic [1:0] ln;
        int p;
        ctl = {IDLE, IDLE};
        oe_n = '0;
        a_h = '0;
        d_h = '0;
        a_en = '1;
        d_en = '0;
        repeat (2) @(posedge clk_sys);
        #1 chk_b("wrap_rst", 1'b1, wrap_n[0]);
        chk_b("wrap_rst_r", 1'b1, wrap_n[1]);
        rst_n = 1'b1;
        for (int i = 0; i < 16; i++) begin
            wr(0, ADDR_W'(i), DATA_W'($random(seed)), 2'b00);
        end
        idle(0);
        @(posedge clk_sys) #1;
        for (int i = 0; i < 30; i++) begin
            p = $random(seed) & 1;
            a = ADDR_W'($random(seed) & 15);
            ln = 2'($random(seed));
            wr(p, a, DATA_W'($random(seed)), ln);
            idle(p);
            rdchk(1 - p, a);
        end
        // write straight after a read with output enable low is dropped
        drv(0, 1'b1, 19'h00003, '0, 2'b00);
        drv(0, 1'b0, 19'h00003, 18'h2aaaa, 2'b00);
        idle(0);
        @(posedge clk_sys) #1;
        rdchk(0, 19'h00003);
        wr(0, 19'h00003, 18'h15555, 2'b00);
        rdchk(0, 19'h00003);
        wr(0, MBOX_ADDR_RIGHT, 18'h12345, 2'b00);
        idle(0);
        @(posedge clk_sys) #1;
        chk_b("mbox_set", 1'b0, mbox_n[1]);
        rdchk(1, MBOX_ADDR_RIGHT);
        chk_b("mbox_clr", 1'b1, mbox_n[1]);
        wr(1, MBOX_ADDR_LEFT, 18'h0abcd, 2'b00);
        idle(1);
        @(posedge clk_sys) #1;
        chk_b("mbox_set_l", 1'b0, mbox_n[0]);
        rdchk(0, MBOX_ADDR_LEFT);
        chk_b("mbox_clr_l", 1'b1, mbox_n[0]);
        // two counting bits from base 10: block 10..13 repeats
        cop(4'h2, 19'h00003);
        cop(4'h3, 19'h00010);
        for (int i = 0; i < 6; i++) begin
            if (i > 0) begin
                cop(4'hb, '0);
                chk_b("wrap", i != 3, wrap_n[0]);
                chk_b("rb_off", 1'b1, aoe_n[0]);
            end
            cop(4'h7, '0);
            chk_b("rb_on", 1'b0, aoe_n[0]);
            chk_w("cnt_rb", 19'h00010 + ADDR_W'(i % 4), a_out[0]);
        end
        cop(4'h6, '0);
        chk_w("msk_rb", 19'h00003, a_out[0]);
        cop(4'hc, '0);
        cop(4'h6, '0);
        chk_w("msk_rst", MASK_RST_VAL, a_out[0]);
        cop(4'hd, '0);
        cop(4'h7, '0);
        chk_w("cnt_clr", CNT_RST_VAL, a_out[0]);
        // read in the same cycle as a counter clear reads the cleared location
        ctl[0] = '{1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0};
        @(posedge clk_sys) #1;
        idle(0);
        @(posedge clk_sys) #1;
        chk_w("clr_rd", {1'b0, mem[CNT_RST_VAL]}, {1'b0, d_out[0]});
        // reads stay off the data lines while output enable is high
        oe_n[0] = 1'b1;
        drv(0, 1'b1, 19'h00003, '0, 2'b00);
        idle(0);
        @(posedge clk_sys) #1;
        chk_b("oe_hold", 1'b1, doe_n[0]);
        chk_w("oe_data", {1'b0, mem[19'h00003]}, {1'b0, d_out[0]});
        oe_n[0] = 1'b0;
        #1 chk_b("oe_on", 1'b0, doe_n[0]);
        idle(0);
        @(posedge clk_sys) #1;
        summarize();
    end
endmodule
bind dprc_dual_port dprc_dual_port_sva i_sva (.clk_sys(clk_sys), .rst_n(rst_n),
    .port_ctl(port_ctl), .output_enable_n(output_enable_n), .addr_in(addr_in),
    .addr_out(addr_out), .addr_oe_n(addr_oe_n), .data_lines_oe_n(data_lines_oe_n),
    .counter_wrap_flag_n(counter_wrap_flag_n), .mailbox_flag_n(mailbox_flag_n));
`default_nettype wire
